// ### logic/gdio_defines.vh
// Purpose: Constants for the general digital I/O port
// Assumes: Register indices are local to one port
// Notes:   Index values are arbitrary within the port's three slots
`ifndef GDIO_DEFINES_VH
`define GDIO_DEFINES_VH
`define GDIO_ADDR_W        2
`define GDIO_IDX_PIN_IN    2'h0
`define GDIO_IDX_DIR       2'h1
`define GDIO_IDX_OUT_VAL   2'h2
`define GDIO_RST_DIR       8'h00
`define GDIO_RST_OUT_VAL   8'h00
`define GDIO_RST_SENSE     8'h00
`endif

// ### logic/gdio_port.v
// Purpose: Eight-bit general digital I/O port with pull-ups and toggle
// Assumes: Single clk; I/O register bus with one-cycle strobes
// Notes:   Pin drive gated by rst combinationally, so hi-z needs no clock
// Operation
// (RULE1) Direction bit one means output
// (RULE2) Pull-up when input, value one, not disabled
// (RULE3) Pull-up off when value zero or output
// (RULE4) Reset tri-states pins even without clock
// (RULE5) Output drives the output value bit
// (RULE6) Writing one to pin location toggles value
// (RULE7) Three addresses: value, direction, pin input
// (RULE8) Global disable kills all pull-ups
// (RULE9) Single-bit writes leave other pins unchanged
// (RULE10) Software steps through intermediate state to output high
// (RULE11) Software steps through intermediate state pull-up/low
// (RULE12) Pin sense readable in any direction
// (RULE13) Latch on clock high, register on rise
// (RULE14) Pin edge seen half to one-and-half periods
// (RULE15) Written value visible one period after write
// (RULE16) Software waits one cycle before readback
// (RULE17) Alternate function leaves other pins alone
// (RULE18) Sleep clamps input unless interrupt pin
// (RULE19) Direction and value reset to zero
`timescale 1ns/1ps
`include "gdio_defines.vh"
module gdio_port #(
    parameter WIDTH = 8
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [1:0]       io_addr,
    input  wire             io_wr,
    input  wire             io_rd,
    input  wire [WIDTH-1:0] io_wdata,
    output reg  [WIDTH-1:0] io_rdata,
    input  wire             global_pullup_disable,
    input  wire             sleep_clamp,
    input  wire [WIDTH-1:0] ext_int_enable,
    input  wire [WIDTH-1:0] alt_dir_override,
    input  wire [WIDTH-1:0] alt_dir_value,
    input  wire [WIDTH-1:0] alt_val_override,
    input  wire [WIDTH-1:0] alt_val_value,
    input  wire [WIDTH-1:0] pin_i,
    output wire [WIDTH-1:0] pin_o,
    output wire [WIDTH-1:0] pin_oe,
    output wire [WIDTH-1:0] pullup_en,
    output wire [WIDTH-1:0] direction_register,
    output wire [WIDTH-1:0] output_value_register,
    output wire [WIDTH-1:0] pin_sense
);


    // Slot codes and reset images
    localparam [1:0]       SLOT_PIN  = `GDIO_IDX_PIN_IN;
    localparam [1:0]       SLOT_DIR  = `GDIO_IDX_DIR;
    localparam [1:0]       SLOT_VAL  = `GDIO_IDX_OUT_VAL;
    localparam [WIDTH-1:0] RST_DIR   = `GDIO_RST_DIR;
    localparam [WIDTH-1:0] RST_VAL   = `GDIO_RST_OUT_VAL;
    localparam [WIDTH-1:0] RST_SENSE = `GDIO_RST_SENSE;
    localparam [WIDTH-1:0] ALL_ZERO  = {WIDTH{1'b0}};

    // Write decode
    wire             wr_dir;
    wire             wr_val;
    wire             wr_tog;

    // Register state per pin, gathered into vectors
    wire [WIDTH-1:0] dir_w;
    wire [WIDTH-1:0] out_val_w;

    // Pad control before reset gating
    wire [WIDTH-1:0] drive_en;
    wire [WIDTH-1:0] drive_val;
    wire [WIDTH-1:0] pull_on;

    // Synchronised pin levels
    wire [WIDTH-1:0] sense_w;

    // Read data path
    reg  [WIDTH-1:0] rdata_nxt;

    // Strobe qualified by slot
    function slot_hit;
        input       strobe;
        input [1:0] addr;
        input [1:0] slot;
        begin
            slot_hit = strobe & (addr == slot);
        end
    endfunction

    // Alternate control where its override is set, register elsewhere
    function ovr_pick;
        input ovr;
        input alt;
        input own;
        begin
            if (ovr) begin
                ovr_pick = alt;
            end else begin
                ovr_pick = own;
            end
        end
    endfunction

    // Pull-up only for an undriven pin whose stored value is one
    function pull_pick;
        input kill;
        input drive;
        input val;
        begin
            pull_pick = ~kill & ~drive & val;
        end
    endfunction

    // Direction slot replaces the bit
    function next_dir_bit;
        input wr;
        input wbit;
        input cur;
        begin
            if (wr) begin
                next_dir_bit = wbit;
            end else begin
                next_dir_bit = cur;
            end
        end
    endfunction

    // Toggle slot never stores, it only inverts
    function next_val_bit;
        input wr;
        input tog;
        input wbit;
        input cur;
        begin
            case ({wr, tog})
                2'h2:    next_val_bit = wbit;
                2'h1:    next_val_bit = cur ^ wbit;
                default: next_val_bit = cur;
            endcase
        end
    endfunction

    // Clamp to ground in sleep unless the pin is an interrupt input
    function clamp_pick;
        input sleep;
        input irq;
        input pin;
        begin
            clamp_pick = pin & ~(sleep & ~irq);
        end
    endfunction

    // Combinational gate; a clocked release would need a running clock
    function gate_rst;
        input r;
        input val;
        begin
            if (r) begin
                gate_rst = 1'b0;
            end else begin
                gate_rst = val;
            end
        end
    endfunction

    // Unmapped slot reads as zero
    function [WIDTH-1:0] read_slot;
        input [1:0]       addr;
        input [WIDTH-1:0] sense;
        input [WIDTH-1:0] dir;
        input [WIDTH-1:0] val;
        begin
            case (addr)
                SLOT_PIN: read_slot = sense; // RULE12
                SLOT_DIR: read_slot = dir;
                SLOT_VAL: read_slot = val;
                default:  read_slot = ALL_ZERO;
            endcase
        end
    endfunction

    // Toggle shares the pin input slot
    assign wr_dir = slot_hit(io_wr, io_addr, SLOT_DIR); // RULE7
    assign wr_val = slot_hit(io_wr, io_addr, SLOT_VAL); // RULE7
    assign wr_tog = slot_hit(io_wr, io_addr, SLOT_PIN); // RULE6

    // One slice per pin
    genvar gi;

    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_pin
            // Stored bits and their next values
            reg  dir_r;
            reg  dir_nxt;
            reg  out_val_r;
            reg  out_val_nxt;

            // Effective pad control
            wire eff_dir;
            wire eff_val;

            // Input path
            wire in_live;
            reg  latch_r;
            reg  sense_r;

            // Next values
            always @* begin
                dir_nxt = next_dir_bit(wr_dir, io_wdata[gi], dir_r); // RULE9
            end

            always @* begin
                out_val_nxt = next_val_bit(wr_val, wr_tog,
                                           io_wdata[gi], out_val_r); // RULE6 RULE9
            end

            // Reset leaves every pin an input without pull-up
            always @(posedge clk) begin
                if (rst) begin
                    dir_r <= RST_DIR[gi]; // RULE19
                end else begin
                    dir_r <= dir_nxt; // RULE1
                end
            end

            always @(posedge clk) begin
                if (rst) begin
                    out_val_r <= RST_VAL[gi]; // RULE19
                end else begin
                    out_val_r <= out_val_nxt; // RULE5
                end
            end

            assign eff_dir = ovr_pick(alt_dir_override[gi],
                                      alt_dir_value[gi],
                                      dir_r); // RULE1 RULE17
            assign eff_val = ovr_pick(alt_val_override[gi],
                                      alt_val_value[gi],
                                      out_val_r); // RULE5 RULE17

            // Stored value decides the pull-up, not the override value
            assign pull_on[gi] = pull_pick(global_pullup_disable,
                                           eff_dir,
                                           out_val_r); // RULE2 RULE3 RULE8

            // Interrupt-enabled pins stay live through sleep
            assign in_live = clamp_pick(sleep_clamp,
                                        ext_int_enable[gi],
                                        pin_i[gi]); // RULE18

            // Falling-edge capture stands in for the clock-high latch
            always @(negedge clk) begin
                latch_r <= in_live; // RULE13 RULE14
            end

            // Second stage; nothing else reads latch_r
            always @(posedge clk) begin
                if (rst) begin
                    sense_r <= RST_SENSE[gi];
                end else begin
                    sense_r <= latch_r; // RULE13 RULE15
                end
            end

            // Vector views for the bus and pads
            assign dir_w[gi]     = dir_r;
            assign out_val_w[gi] = out_val_r;
            assign drive_en[gi]  = eff_dir;
            assign drive_val[gi] = eff_val;
            assign sense_w[gi]   = sense_r;
        end
    endgenerate

    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_out
            // Pins release the moment rst rises, clock or not
            assign pin_oe[gi]    = gate_rst(rst, drive_en[gi]); // RULE4 RULE1
            assign pin_o[gi]     = gate_rst(rst, drive_val[gi]); // RULE4 RULE5
            assign pullup_en[gi] = gate_rst(rst, pull_on[gi]); // RULE4 RULE2 RULE3 RULE8
        end
    endgenerate

    // Read data holds until the next read strobe
    always @* begin
        rdata_nxt = io_rdata;
        if (io_rd) begin
            rdata_nxt = read_slot(io_addr, sense_w, dir_w, out_val_w); // RULE7 RULE12
        end
    end

    // Registered so the bus sees a steady byte
    always @(posedge clk) begin
        if (rst) begin
            io_rdata <= ALL_ZERO;
        end else begin
            io_rdata <= rdata_nxt;
        end
    end

    // Register copies for the core
    assign direction_register    = dir_w;
    assign output_value_register = out_val_w;
    assign pin_sense             = sense_w;

endmodule // gdio_port

// ### bench/gdio_pins_model.sv
// Purpose: Board signals on the port pins
// Assumes: Weak board drive
// Notes:   Pad drive and pull-up win over the board
`timescale 1ns/1ps
module gdio_pins_model (
    input  wire [7:0] pin_o,
    input  wire [7:0] pin_oe,
    input  wire [7:0] pullup_en,
    input  wire [7:0] ext_v,
    output wire [7:0] pin_i
);
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & (pullup_en | ext_v));
endmodule // gdio_pins_model

// ### bench/gdio_port_chk.sv
// Purpose: Concurrent checks on the port pins and registers
// Assumes: Sees the port's own ports only
// Notes:   Bound below; pin sense lags the gated pin by one clock cycle
`timescale 1ns/1ps
module gdio_port_chk (
    input wire       clk,
    input wire       rst,
    input wire       io_wr,
    input wire       global_pullup_disable,
    input wire       sleep_clamp,
    input wire [1:0] io_addr,
    input wire [7:0] io_wdata,
    input wire [7:0] ext_int_enable,
    input wire [7:0] alt_dir_override,
    input wire [7:0] alt_dir_value,
    input wire [7:0] alt_val_override,
    input wire [7:0] alt_val_value,
    input wire [7:0] pin_i,
    input wire [7:0] pin_o,
    input wire [7:0] pin_oe,
    input wire [7:0] pullup_en,
    input wire [7:0] direction_register,
    input wire [7:0] output_value_register,
    input wire [7:0] pin_sense
);
    wire [7:0] d = direction_register;
    wire [7:0] v = output_value_register;
    wire [7:0] e = (alt_dir_override & alt_dir_value) | (~alt_dir_override & d);
    wire [7:0] o = (alt_val_override & alt_val_value) | (~alt_val_override & v);
    wire [7:0] u = ~e & v & ~{8{global_pullup_disable}};
    wire [7:0] g = pin_i & (ext_int_enable | ~{8{sleep_clamp}});
    wire [3:0] w = {4{io_wr}} & (4'h1 << io_addr);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    oe_dir_a: assert property (pin_oe == e) else $error("oe");
    alt_keep_a: assert property ((pin_oe & ~alt_dir_override) == (d & ~alt_dir_override))
        else $error("alt");
    drive_val_a: assert property ((pin_o & e) == (o & e)) else $error("drive");
    pull_sel_a: assert property (pullup_en == u) else $error("pull");
    sense_lag_a: assert property (!$past(rst) |-> pin_sense == $past(g))
        else $error("sense");
    rst_hiz_a: assert property (disable iff (1'b0) rst |-> !(pin_oe | pullup_en))
        else $error("hiz");
    pin_tog_a: assert property (w[0] |=> v == ($past(v) ^ $past(io_wdata)))
        else $error("tog");
    dir_wr_a: assert property (w[1] |=> d == $past(io_wdata)) else $error("dir");
    val_wr_a: assert property (w[2] |=> v == $past(io_wdata)) else $error("val");
    rst_val_a: assert property ($fell(rst) |-> (d | v) == 8'h00) else $error("init");
    cover property (w[0] && io_wdata != 8'h00);
    cover property (pullup_en != 8'h00);
    cover property (global_pullup_disable && w[2]);
    cover property (sleep_clamp && pin_i != 8'h00 && pin_sense == 8'h00);
endmodule // gdio_port_chk
bind gdio_port gdio_port_chk u_chk (.*);

// ### bench/gdio_port_tb_top.sv
// Purpose: Random and corner-case test of the port
// Assumes: Board drives weakly behind pads and pull-ups
// Notes:   Fixed seed; one mid-run reset
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
    tests_run++; \
    if ((s) !== (e)) begin \
        failures++; \
        $display("wrong value %s expected %h seen %h", n, e, s); \
    end \
end
module gdio_port_tb_top;
    logic       clk = 0, rst = 1, io_wr = 0, io_rd = 0, global_pullup_disable = 0, sleep_clamp = 0;
    logic [1:0] io_addr = 2'h0;
    logic [7:0] io_wdata = 8'h00, ext_int_enable = 8'h00, ext_v = 8'h00, d = 8'h00, v = 8'h00;
    logic [7:0] alt_dir_override = 8'h00, alt_dir_value = 8'h00;
    logic [7:0] alt_val_override = 8'h00, alt_val_value = 8'h00;
    wire  [7:0] io_rdata, pin_o, pin_oe, pullup_en, pin_i, direction_register;
    wire  [7:0] output_value_register, pin_sense;
    int         failures = 0, tests_run = 0;
    always #12.5 clk = ~clk;
    gdio_port DUT (.*);
    gdio_pins_model u_pins (.*);
    // Idle cycle between accesses keeps strobes single-driven per step
    task acc(input w, input [1:0] a, input [7:0] x);
        {io_addr, io_wdata, io_wr, io_rd} = {a, x, w, !w};
        @(posedge clk) #1 {io_wr, io_rd} = 2'b00;
        if (!w) `CHK("rdata", x, io_rdata)
        @(posedge clk) #1;
    endtask
    function automatic [7:0] lvl();
        logic [7:0] e, o;
        e = (alt_dir_override & alt_dir_value) | (~alt_dir_override & d);
        o = (alt_val_override & alt_val_value) | (~alt_val_override & v);
        return ((e & o) | (~e & ((v & ~{8{global_pullup_disable}}) | ext_v)))
            & (ext_int_enable | ~{8{sleep_clamp}});
    endfunction
    task step(input [17:0] env, input [31:0] alt, input [7:0] nv, nd, tg);
        {global_pullup_disable, sleep_clamp, ext_int_enable, ext_v} = env;
        {alt_dir_override, alt_dir_value, alt_val_override, alt_val_value} = alt;
        acc(1, 2'h2, nv); v = nv;
        acc(1, 2'h1, nd); d = nd;
        acc(1, 2'h0, tg); v ^= tg;
        acc(1, 2'h3, nd ^ tg);
        acc(0, 2'h3, 8'h00);
        acc(0, 2'h1, d);
        acc(0, 2'h2, v);
        acc(0, 2'h0, lvl());
    endtask
    task tally_and_finish;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial #1000000 begin failures++; tally_and_finish; end
    initial begin
        void'($urandom(94));
        repeat (8) @(posedge clk);
        #1 rst = 0;
        step(18'h3ffff, 32'h0, 8'hff, 8'h00, 8'h00);
        step(18'h0ff00, 32'h0, 8'hff, 8'h00, 8'h00);
        step(18'h10000, 32'h0, 8'hff, 8'h0f, 8'h00);
        step(18'h0ff00, 32'hf0f00f0f, 8'h00, 8'h00, 8'h00);
        repeat (200) begin
            step(18'($urandom), $urandom & $urandom, 8'($urandom), 8'($urandom),
                 8'($urandom));
        end
        acc(1, 2'h1, 8'hff); d = 8'hff;
        #5 rst = 1;
        #1 `CHK("oe in reset", 8'h00, pin_oe)
        `CHK("pull in reset", 8'h00, pullup_en)
        repeat (2) @(posedge clk);
        #1 rst = 0;
        {d, v} = 16'h0000;
        `CHK("dir after reset", 8'h00, direction_register)
        `CHK("val after reset", 8'h00, output_value_register)
        step(18'h0ff00, 32'h0, 8'h5a, 8'h0f, 8'h81);
        tally_and_finish;
    end
endmodule // gdio_port_tb_top
